// ===== hw/sbs_port.sv
// synchronous burst sram port: pipeline, burst counter, write buffer
//
// Behaviour
// - load on enabled edge, selected, load low; direction from read_write_n.
// - load high on enabled edge advances the internal burst counter.
// - read_write_n ignored while advancing; burst keeps loaded direction.
// - burst direction fixed by read_write_n on its load cycle.
// - load low while deselected is a deselect; no new operation.
// - data bus released one cycle after deselect; pending phase finishes.
// - selected only when both low selects low and high select high.
// - advance after deselect or noop is a noop; bus stays released.
// - clock gate high makes the edge ignored, except output enable and write buffer drain.
// - suspended cycle holds phase, burst and drive state and the driven read data.
// - data bus released from power-up until an operation is loaded.
// - strobe k writes byte lane k plus parity bit k; none, no write.
// - any strobe mix allowed; unselected lanes keep stored contents.
// - narrow configuration has only the first two strobes and lanes.
// - interleaved order: low address bits are start xor count.
// - linear order: low address bits count up modulo four.
// - counter wraps to start value after fourth word and continues.
// - burst read outputs one word per enabled advancing cycle.
// - read data valid after the edge following the load.
// - a new load ends any running burst and replaces it.
// - only the two low address bits advance during a burst.
`timescale 1ns/1ps
`default_nettype none

module sbs_buf
	import sbs_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i
);

	localparam int CNT_W = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [CNT_W-1:0] count_ff;
	logic [CNT_W-1:0] nxt_count;
	logic [CNT_W-1:0] wr_idx;
	logic ready_ff;
	logic valid_ff;
	logic push;
	logic pop;

	assign push = in_valid_i & ready_ff;
	assign pop = valid_ff & out_ready_i;
	assign nxt_count = count_ff + CNT_W'(push) - CNT_W'(pop);
	assign wr_idx = pop ? CNT_W'(count_ff - CNT_W'(1)) : count_ff;

	// head always sits in entry zero so the output is a flop
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_ff[i] <= '0;
			end
		end else begin
			for (int i = 0; i < DEPTH; i++) begin
				if (push && wr_idx == CNT_W'(i)) begin
					mem_ff[i] <= in_data_i;
				end else if (pop && i < DEPTH - 1) begin
					mem_ff[i] <= mem_ff[(i + 1) % DEPTH];
				end
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			count_ff <= '0;
			ready_ff <= 1'h1;
			valid_ff <= 1'h0;
		end else begin
			count_ff <= nxt_count;
			ready_ff <= nxt_count != CNT_W'(DEPTH);
			valid_ff <= nxt_count != CNT_W'(0);
		end
	end

	assign in_ready_o = ready_ff;
	assign out_valid_o = valid_ff;
	assign out_data_o = mem_ff[0];

endmodule

module sbs_port
	import sbs_pkg::*;
#(
	parameter bit NARROW_CFG = 1'b0
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic read_write_n_i,
	input wire logic advance_load_n_i,
	input wire logic clock_gate_n_i,
	input wire logic chip_select_a_n_i,
	input wire logic chip_select_b_i,
	input wire logic chip_select_c_n_i,
	input wire logic [LANES-1:0] byte_write_strobe_n_i,
	input wire logic burst_order_select_i,
	input wire logic output_enable_n_i,
	input wire logic [DATA_W-1:0] dq_i,
	output logic [DATA_W-1:0] dq_o,
	output logic dq_oe_o,
	output logic rd_en_o,
	output logic [ADDR_W-1:0] rd_addr_o,
	input wire logic [DATA_W-1:0] rd_data_i,
	output logic wr_valid_o,
	output logic [ADDR_W-1:0] wr_addr_o,
	output logic [DATA_W-1:0] wr_data_o,
	output logic [DATA_W-1:0] wr_mask_o,
	input wire logic wr_ready_i,
	output logic wr_space_o
);

	logic enabled;
	logic selected;
	logic oe_s1_ff;
	logic oe_s2_ff;
	logic active_ff;
	logic dir_ff;
	logic [ADDR_W-1:0] base_ff;
	logic [BURST_W-1:0] start_ff;
	logic [BURST_W-1:0] cnt_ff;
	logic [BURST_W-1:0] nxt_cnt;
	logic [ADDR_W-1:0] burst_addr;
	sbs_phase_type phase_ff;
	sbs_phase_type nxt_phase;
	logic rd_en_ff;
	logic [ADDR_W-1:0] rd_addr_ff;
	logic drive_ff;
	logic nxt_drive;
	logic dq_oe_ff;
	logic [DATA_W-1:0] dq_ff;
	logic [LANES-1:0] lane_en;
	logic [DATA_W-1:0] wr_mask;
	logic wr_in_valid;
	sbs_wreq_type wr_in;
	sbs_wreq_type wr_out;

	function automatic logic [BURST_W-1:0] sbs_seq(
		input logic [BURST_W-1:0] start,
		input logic [BURST_W-1:0] cnt,
		input logic interleave
	);
		logic [BURST_W-1:0] res;
		res = interleave ? (start ^ cnt) : BURST_W'(start + cnt);
		return res;
	endfunction

	assign enabled = ~clock_gate_n_i;
	assign selected = ~chip_select_a_n_i & chip_select_b_i &
		~chip_select_c_n_i;

	// output enable arrives asynchronously; two stages before use
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			oe_s1_ff <= OE_SYNC_RST;
			oe_s2_ff <= OE_SYNC_RST;
		end else begin
			oe_s1_ff <= output_enable_n_i;
			oe_s2_ff <= oe_s1_ff;
		end
	end

	// counter wraps mod four, so the fifth word repeats the first
	assign nxt_cnt = BURST_W'(cnt_ff + CNT_STEP);
	// upper bits stay at the loaded value
	assign burst_addr = {base_ff[ADDR_W-1:BURST_W],
		sbs_seq(start_ff, nxt_cnt, burst_order_select_i)};

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			active_ff <= 1'h0;
			dir_ff <= 1'h0;
			base_ff <= ADDR_RST;
			start_ff <= CNT_RST;
			cnt_ff <= CNT_RST;
		end else if (enabled) begin
			if (!advance_load_n_i) begin
				if (selected) begin
					// a fresh load replaces any burst in flight
					active_ff <= 1'h1;
					dir_ff <= ~read_write_n_i;
					base_ff <= addr_i;
					start_ff <= addr_i[BURST_W-1:0];
					cnt_ff <= CNT_RST;
				end else begin
					active_ff <= 1'h0;
				end
			end else if (active_ff) begin
				cnt_ff <= nxt_cnt;
			end
		end
	end

	// operation whose data phase falls on the next enabled edge
	always_comb begin
		nxt_phase = phase_ff;
		if (enabled) begin
			nxt_phase = PHASE_RST;
			if (!advance_load_n_i) begin
				nxt_phase.valid = selected;
				nxt_phase.write = ~read_write_n_i;
				nxt_phase.addr = addr_i;
				nxt_phase.strobe_n = byte_write_strobe_n_i;
			end else if (active_ff) begin
				nxt_phase.valid = 1'h1;
				nxt_phase.write = dir_ff;
				nxt_phase.addr = burst_addr;
				nxt_phase.strobe_n = byte_write_strobe_n_i;
			end else begin
				nxt_phase.valid = 1'h0;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			phase_ff <= PHASE_RST;
			rd_en_ff <= 1'h0;
			rd_addr_ff <= ADDR_RST;
		end else begin
			phase_ff <= nxt_phase;
			// array answers within the cycle that rd_en_o is high
			rd_en_ff <= nxt_phase.valid & ~nxt_phase.write;
			rd_addr_ff <= nxt_phase.addr;
		end
	end

	// suspended edges keep the previous drive decision
	assign nxt_drive = enabled ? (phase_ff.valid & ~phase_ff.write)
		: drive_ff;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			drive_ff <= DRIVE_RST;
			dq_oe_ff <= DRIVE_RST;
			dq_ff <= DQ_RST;
		end else begin
			drive_ff <= nxt_drive;
			// output enable is honoured even while suspended
			dq_oe_ff <= nxt_drive & ~oe_s2_ff;
			if (enabled && phase_ff.valid && !phase_ff.write) begin
				dq_ff <= rd_data_i;
			end
		end
	end

	// a write loses its word if the buffer is full; watch wr_space_o
	assign lane_en = ~phase_ff.strobe_n &
		(NARROW_CFG ? LANES_NARROW : LANES_WIDE);

	for (genvar g = 0; g < LANES; g++) begin : g_lane
		assign wr_mask[g*LANE_W +: LANE_W] = {LANE_W{lane_en[g]}};
		assign wr_mask[PAR_BASE+g] = lane_en[g];
	end

	// write data is taken on the edge after the load
	assign wr_in_valid = enabled & phase_ff.valid & phase_ff.write;
	assign wr_in.addr = phase_ff.addr;
	assign wr_in.data = dq_i;
	assign wr_in.mask = wr_mask;

	sbs_buf #(
		.WIDTH(WREQ_W),
		.DEPTH(BUF_DEPTH)
	) u_wbuf (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.in_valid_i(wr_in_valid),
		.in_data_i(wr_in),
		.in_ready_o(wr_space_o),
		.out_valid_o(wr_valid_o),
		.out_data_o(wr_out),
		.out_ready_i(wr_ready_i)
	);

	assign wr_addr_o = wr_out.addr;
	assign wr_data_o = wr_out.data;
	assign wr_mask_o = wr_out.mask;
	assign dq_o = dq_ff;
	assign dq_oe_o = dq_oe_ff;
	assign rd_en_o = rd_en_ff;
	assign rd_addr_o = rd_addr_ff;

	AST_LOAD_READ:
	assert property (@(posedge clk_i) disable iff (!rst_b_i)
		enabled && !advance_load_n_i && selected && read_write_n_i
		|=> rd_en_o && rd_addr_o == $past(addr_i))
	else $error("load read did not issue its address");

	AST_LOAD_WRITE_DIR:
	assert property (@(posedge clk_i) disable iff (!rst_b_i)
		enabled && !advance_load_n_i && selected && !read_write_n_i
		|=> phase_ff.valid && phase_ff.write && dir_ff)
	else $error("load write did not set write direction");

	AST_BURST_DIR:
	assert property (@(posedge clk_i) disable iff (!rst_b_i)
		enabled && advance_load_n_i && active_ff
		|=> phase_ff.valid && phase_ff.write == $past(dir_ff))
	else $error("burst changed direction");

	AST_BURST_UPPER:
	assert property (@(posedge clk_i) disable iff (!rst_b_i)
		enabled && advance_load_n_i && active_ff
		|=> phase_ff.addr[ADDR_W-1:BURST_W]
			== $past(base_ff[ADDR_W-1:BURST_W]))
	else $error("upper address moved during burst");

	AST_LINEAR_STEP:
	assert property (@(posedge clk_i) disable iff (!rst_b_i)
		enabled && advance_load_n_i && active_ff && !burst_order_select_i
		|=> phase_ff.addr[BURST_W-1:0]
			== BURST_W'($past(phase_ff.addr[BURST_W-1:0]) + 2'h1))
	else $error("linear burst step wrong");

	AST_INTERLEAVE_STEP:
	assert property (@(posedge clk_i) disable iff (!rst_b_i)
		enabled && advance_load_n_i && active_ff && burst_order_select_i
		|=> phase_ff.addr[BURST_W-1:0]
			== ($past(start_ff) ^ BURST_W'($past(cnt_ff) + 2'h1)))
	else $error("interleaved burst step wrong");

	AST_DESELECT_NOOP:
	assert property (@(posedge clk_i) disable iff (!rst_b_i)
		enabled && !advance_load_n_i && !selected
		|=> !phase_ff.valid && !active_ff && !rd_en_o)
	else $error("deselect started an operation");

	AST_DESELECT_HIZ:
	assert property (@(posedge clk_i) disable iff (!rst_b_i)
		enabled && !advance_load_n_i && !selected ##1 enabled
		|=> !dq_oe_o)
	else $error("bus still driven after deselect");

	AST_SUSPEND_HOLD:
	assert property (@(posedge clk_i) disable iff (!rst_b_i)
		clock_gate_n_i
		|=> $stable(phase_ff) && $stable(dq_o) && $stable(drive_ff)
			&& $stable(cnt_ff))
	else $error("state moved on a suspended edge");

	AST_NO_STROBE_NO_WRITE:
	assert property (@(posedge clk_i) disable iff (!rst_b_i)
		enabled && !advance_load_n_i && selected && !read_write_n_i
			&& byte_write_strobe_n_i[1] ##1 enabled
		|-> wr_in_valid && wr_in.mask[2*LANE_W-1:LANE_W] == 8'h00
			&& !wr_in.mask[PAR_BASE+1])
	else $error("unstrobed lane one was written");

	AST_OE_HIZ:
	assert property (@(posedge clk_i) disable iff (!rst_b_i)
		oe_s2_ff |=> !dq_oe_o)
	else $error("bus driven with output enable high");

endmodule

`default_nettype wire

// ===== hw/sbs_pkg.sv
// constants and carrier types for the synchronous burst sram port
package sbs_pkg;

	localparam int ADDR_W = 18;
	localparam int DATA_W = 36;
	localparam int LANES = 4;
	localparam int LANE_W = 8;
	localparam int PAR_BASE = 32;
	localparam int BURST_W = 2;
	localparam int BUF_DEPTH = 2;

	// data phase follows the address phase by one enabled edge
	localparam int DATA_LAT_CYC = 1;

	localparam logic [BURST_W-1:0] CNT_RST = 2'h0;
	localparam logic [BURST_W-1:0] CNT_STEP = 2'h1;

	// lanes present in the wide and in the narrow configuration
	localparam logic [LANES-1:0] LANES_WIDE = 4'hF;
	localparam logic [LANES-1:0] LANES_NARROW = 4'h3;

	localparam logic OE_SYNC_RST = 1'h1;
	localparam logic DRIVE_RST = 1'h0;
	localparam logic [DATA_W-1:0] DQ_RST = 36'h0;
	localparam logic [ADDR_W-1:0] ADDR_RST = 18'h0;

	typedef struct packed {
		logic valid;
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [LANES-1:0] strobe_n;
	} sbs_phase_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [DATA_W-1:0] mask;
	} sbs_wreq_type;

	localparam sbs_phase_type PHASE_RST = '0;
	localparam int WREQ_W = $bits(sbs_wreq_type);

endpackage

// ===== tb/sbs_array_model.sv
// storage array model behind the sram port, with a stallable write side
`timescale 1ns/1ps
`default_nettype none
module sbs_array_model
	import sbs_pkg::*;
(
	input wire logic clk_i,
	input wire logic rd_en_i,
	input wire logic [ADDR_W-1:0] rd_addr_i,
	output logic [DATA_W-1:0] rd_data_o,
	input wire logic wr_valid_i,
	input wire logic [ADDR_W-1:0] wr_addr_i,
	input wire logic [DATA_W-1:0] wr_data_i,
	input wire logic [DATA_W-1:0] wr_mask_i,
	input wire logic stall_i,
	output logic wr_ready_o
);
	logic [DATA_W-1:0] mem [16];
	logic [DATA_W-1:0] junk = 36'h5A5A5A5A5;
	initial begin
		foreach (mem[i]) mem[i] = '0;
	end
	// no read pending: lines toggle so a stale word never matches
	always @(posedge clk_i) begin
		junk <= ~junk;
	end
	assign rd_data_o = rd_en_i ? mem[rd_addr_i[3:0]] : junk;
	assign wr_ready_o = !stall_i;
	// only masked bits change, the other lanes stay
	always @(posedge clk_i) begin
		if (wr_valid_i && wr_ready_o) begin
			mem[wr_addr_i[3:0]] <= (mem[wr_addr_i[3:0]] & ~wr_mask_i) |
				(wr_data_i & wr_mask_i);
		end
	end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the synchronous burst sram port
`timescale 1ns/1ps
`default_nettype none
module testbench
	import sbs_pkg::*;
;
	localparam logic [ADDR_W-1:0] BASE = 18'h2A4C0;
	localparam logic [2:0] SEL = 3'h2;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic clock_gate_n_i = 1'b0;
	logic advance_load_n_i = 1'b0;
	logic read_write_n_i = 1'b1;
	logic chip_select_a_n_i = 1'b1;
	logic chip_select_b_i = 1'b0;
	logic chip_select_c_n_i = 1'b1;
	logic burst_order_select_i = 1'b0;
	logic output_enable_n_i = 1'b0;
	logic stall = 1'b0;
	logic [ADDR_W-1:0] addr_i = '0;
	logic [LANES-1:0] byte_write_strobe_n_i = 4'hF;
	logic [DATA_W-1:0] dq_i = '0;
	logic [DATA_W-1:0] dq_o, rd_data_i, wr_data_o, wr_mask_o;
	logic [DATA_W-1:0] n_mask;
	logic [ADDR_W-1:0] rd_addr_o, wr_addr_o;
	logic dq_oe_o, rd_en_o, wr_valid_o, wr_ready_i, wr_space_o;
	int mismatches = 0;
	int n_compared = 0;
	int cycles = 0;

	always #2 clk_i = ~clk_i;

	sbs_port sbs_port_i (
		.clk_i, .rst_b_i, .addr_i, .read_write_n_i, .advance_load_n_i,
		.clock_gate_n_i, .chip_select_a_n_i, .chip_select_b_i,
		.chip_select_c_n_i, .byte_write_strobe_n_i, .burst_order_select_i,
		.output_enable_n_i, .dq_i, .dq_o, .dq_oe_o, .rd_en_o, .rd_addr_o,
		.rd_data_i, .wr_valid_o, .wr_addr_o, .wr_data_o, .wr_mask_o,
		.wr_ready_i, .wr_space_o
	);
	sbs_array_model sbs_array_model_i (
		.clk_i, .rd_en_i(rd_en_o), .rd_addr_i(rd_addr_o),
		.rd_data_o(rd_data_i), .wr_valid_i(wr_valid_o),
		.wr_addr_i(wr_addr_o), .wr_data_i(wr_data_o),
		.wr_mask_i(wr_mask_o), .stall_i(stall), .wr_ready_o(wr_ready_i)
	);
	// narrow copy on the same pins, only its lane mask is watched
	sbs_port #(.NARROW_CFG(1'b1)) sbs_port_narrow_i (
		.clk_i, .rst_b_i, .addr_i, .read_write_n_i, .advance_load_n_i,
		.clock_gate_n_i, .chip_select_a_n_i, .chip_select_b_i,
		.chip_select_c_n_i, .byte_write_strobe_n_i, .burst_order_select_i,
		.output_enable_n_i, .dq_i, .dq_o(), .dq_oe_o(), .rd_en_o(),
		.rd_addr_o(), .rd_data_i, .wr_valid_o(), .wr_addr_o(),
		.wr_data_o(), .wr_mask_o(n_mask), .wr_ready_i, .wr_space_o()
	);

	function automatic logic [DATA_W-1:0] dat(input int i);
		return 36'h512345670 + DATA_W'(i);
	endfunction
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [DATA_W-1:0] exp,
		input logic [DATA_W-1:0] got);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// entered at a falling edge, returns one rising edge later
	task automatic drive(input logic g, input logic a, input logic r,
		input logic [2:0] s, input logic [ADDR_W-1:0] ad,
		input logic [LANES-1:0] b, input logic [DATA_W-1:0] d);
		{clock_gate_n_i, advance_load_n_i, read_write_n_i, chip_select_a_n_i,
			chip_select_b_i, chip_select_c_n_i, addr_i,
			byte_write_strobe_n_i, dq_i} = {g, a, r, s, ad, b, d};
		@(negedge clk_i);
	endtask
	task automatic ld(input logic r, input logic [ADDR_W-1:0] a,
		input logic [LANES-1:0] b, input logic [DATA_W-1:0] d);
		drive(1'b0, 1'b0, r, SEL, a, b, d);
	endtask
	// read_write_n held high on advances: a write burst must stay a write
	task automatic nx(input logic [LANES-1:0] b, input logic [DATA_W-1:0] d);
		drive(1'b0, 1'b1, 1'b1, SEL, '0, b, d);
	endtask
	task automatic ds(input logic [2:0] s, input logic [DATA_W-1:0] d);
		drive(1'b0, 1'b0, 1'b1, s, '0, 4'hF, d);
	endtask
	task automatic idle(input int n);
		repeat (n) ds(3'h7, '0);
	endtask

	task automatic t_reset();
		chk("drive at start", '0, DATA_W'(dq_oe_o));
		$display("done reset");
	endtask
	task automatic t_lanes();
		ld(1'b0, BASE | 18'h5, 4'h0, '0);
		ld(1'b0, BASE | 18'h5, 4'hA, 36'hFFFFFFFFF);
		chk("wr valid", 36'h1, DATA_W'(wr_valid_o));
		chk("wr data", 36'hFFFFFFFFF, wr_data_o);
		chk("wr mask", 36'hFFFFFFFFF, wr_mask_o);
		chk("narrow mask", 36'h30000FFFF, n_mask);
		ds(3'h7, '0);
		idle(3);
		ld(1'b1, BASE | 18'h5, 4'hF, '0);
		ds(3'h7, '0);
		chk("lanes", 36'hAFF00FF00, dq_o);
		chk("read drive", 36'h1, DATA_W'(dq_oe_o));
		$display("done lanes");
	endtask
	task automatic t_fill();
		burst_order_select_i = 1'b0;
		ld(1'b0, BASE, 4'h0, '0);
		for (int i = 0; i < 3; i++) nx(4'h0, dat(i));
		ds(3'h7, dat(3));
		idle(4);
		$display("done fill");
	endtask
	task automatic t_rburst(input logic il, input logic [1:0] st);
		logic [1:0] q;
		burst_order_select_i = il;
		ld(1'b1, BASE | 18'(st), 4'hF, '0);
		for (int k = 1; k < 7; k++) begin
			nx(4'hF, '0);
			q = il ? st ^ 2'(k - 1) : st + 2'(k - 1);
			chk("burst data", dat(q), dq_o);
			q = il ? st ^ 2'(k) : st + 2'(k);
			chk("burst addr", DATA_W'(BASE | 18'(q)), DATA_W'(rd_addr_o));
		end
		ds(3'h7, '0);
		$display("done burst");
	endtask
	task automatic t_suspend();
		burst_order_select_i = 1'b0;
		ld(1'b1, BASE, 4'hF, '0);
		nx(4'hF, '0);
		drive(1'b1, 1'b0, 1'b0, 3'h7, '0, 4'h0, '0);
		drive(1'b1, 1'b0, 1'b0, 3'h7, '0, 4'h0, '0);
		chk("held data", dat(0), dq_o);
		chk("held drive", 36'h1, DATA_W'(dq_oe_o));
		nx(4'hF, '0);
		chk("resumed", dat(1), dq_o);
		ld(1'b1, BASE | 18'h3, 4'hF, '0);
		chk("cut addr", DATA_W'(BASE | 18'h3), DATA_W'(rd_addr_o));
		chk("cut word", dat(2), dq_o);
		ds(3'h7, '0);
		chk("new word", dat(3), dq_o);
		$display("done suspend");
	endtask
	task automatic t_deselect();
		logic [2:0] pat [3] = '{3'h6, 3'h0, 3'h3};
		foreach (pat[i]) begin
			ld(1'b1, BASE, 4'hF, '0);
			ds(pat[i], '0);
			chk("pending word", dat(0), dq_o);
			chk("no new read", '0, DATA_W'(rd_en_o));
			nx(4'hF, '0);
			chk("released", '0, DATA_W'(dq_oe_o));
			chk("noop read", '0, DATA_W'(rd_en_o));
		end
		$display("done deselect");
	endtask
	task automatic t_oe();
		output_enable_n_i = 1'b1;
		idle(3);
		ld(1'b1, BASE, 4'hF, '0);
		ds(3'h7, '0);
		chk("oe high", '0, DATA_W'(dq_oe_o));
		output_enable_n_i = 1'b0;
		idle(3);
		$display("done oe");
	endtask
	task automatic t_stall();
		stall = 1'b1;
		ld(1'b0, BASE | 18'h8, 4'h0, '0);
		ld(1'b0, BASE | 18'h9, 4'h0, dat(8));
		ld(1'b0, BASE | 18'hA, 4'h0, dat(9));
		chk("space", '0, DATA_W'(wr_space_o));
		ds(3'h7, dat(10));
		chk("head", DATA_W'(BASE | 18'h8), DATA_W'(wr_addr_o));
		stall = 1'b0;
		idle(4);
		ld(1'b1, BASE | 18'h8, 4'hF, '0);
		ld(1'b1, BASE | 18'h9, 4'hF, '0);
		chk("kept 0", dat(8), dq_o);
		ld(1'b1, BASE | 18'hA, 4'hF, '0);
		chk("kept 1", dat(9), dq_o);
		ds(3'h7, '0);
		chk("lost", '0, dq_o);
		$display("done stall");
	endtask

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			mismatches++;
			wrap_up();
		end
	end
	initial begin
		repeat (4) @(posedge clk_i);
		@(negedge clk_i);
		rst_b_i = 1'b1;
		idle(4);
		t_reset();
		t_lanes();
		t_fill();
		t_rburst(1'b0, 2'h1);
		t_rburst(1'b1, 2'h1);
		t_rburst(1'b1, 2'h2);
		t_suspend();
		t_deselect();
		t_oe();
		t_stall();
		wrap_up();
	end
endmodule
`default_nettype wire
